// File: src/eau_top.sv
// effective address unit: mode decode, indirection, byte and bit pointers
//
// Overview of operation
// - logical word addresses are 15 bits wide
// - address after the highest wraps to zero
// - enabled translation maps logical to 20-bit physical
// - short form: bit5 indirect, 6-7 mode, 8-15 displacement
// - extended: mode per opcode, next word indirect/displacement
// - displacement unsigned in absolute, signed otherwise
// - mode 00 abs, 01 pc, 10 acc2, 11 acc3
// - absolute intermediate address is the displacement
// - pc relative adds to displacement word address
// - accumulator relative adds to named base accumulator
// - top bit of pc or accumulator ignored
// - sums wrap by dropping the carry
// - translate intermediate address before indirection or access
// - indirect: fetch pointer, repeat while its bit0 set
// - chain ends at clear indirect bit
// - protected chains limited to LEVEL_MAX levels, fifteen by default
// - byte pointer: bits 0-14 word, bit 15 select
// - byte pointers never indirect
// - bit address: resolved base plus unsigned offset
// - bit position from destination bits 12-15
// - accumulators untouched; same accumulator means zero base
`timescale 1ns/100ps
module eau_top #(
  parameter int LEVEL_MAX = eau_pkg::LEVEL_MAX
) (
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  input  wire logic                 req_valid_i,
  input  eau_pkg::eau_kind_t        req_kind_i,
  input  wire logic                 extended_i,
  input  wire logic [1:0]           ext_field_i,
  input  wire logic [15:0]          instr_i,
  input  wire logic [15:0]          ext_word_i,
  input  wire logic [15:0]          pc_i,
  input  wire logic [15:0]          base_accumulator_two_i,
  input  wire logic [15:0]          base_accumulator_three_i,
  input  wire logic [15:0]          byte_ptr_i,
  input  wire logic [15:0]          src_acc_i,
  input  wire logic [15:0]          dst_acc_i,
  input  wire logic                 same_acc_i,
  input  wire logic                 map_enable_i,
  input  wire logic                 indirect_prot_i,
  output logic                      xlat_req_o,
  output logic [14:0]               xlat_laddr_o,
  input  wire logic                 xlat_ack_i,
  input  wire logic [19:0]          xlat_paddr_i,
  output logic                      mem_rd_o,
  output logic [19:0]               mem_paddr_o,
  input  wire logic                 mem_ack_i,
  input  wire logic [15:0]          mem_data_i,
  output logic                      busy_o,
  output logic                      done_o,
  output logic                      prot_fault_o,
  output logic [14:0]               ea_o,
  output logic [19:0]               ea_phys_o,
  output logic                      byte_sel_o,
  output logic [3:0]                bit_pos_o
);

  if (LEVEL_MAX < 1 || LEVEL_MAX > 15) begin : g_bad_level
    $error("LEVEL_MAX must lie in 1..15");
  end

  localparam logic [3:0] LVL_LIMIT = 4'(LEVEL_MAX);

  typedef struct packed {
    eau_pkg::eau_state_t st;
    logic [14:0]         ia;
    logic                ind;
    logic [3:0]          lvl;
    logic [14:0]         ofs;
    logic                bsel;
    logic [3:0]          bitpos;
    logic [19:0]         paddr;
  } eau_regs_t;

  eau_regs_t s_r;
  eau_regs_t s_nxt;

  eau_calc_if cif ();

  assign cif.instr    = instr_i;
  assign cif.ext_word = ext_word_i;
  assign cif.extended = extended_i;
  assign cif.fld      = ext_field_i;
  assign cif.pc       = pc_i;
  assign cif.acc2     = base_accumulator_two_i;
  assign cif.acc3     = base_accumulator_three_i;

  eau_calc u_calc (
    .cif (cif)
  );

  logic accept;
  logic add_now;
  logic xlat_done;

  assign accept    = req_valid_i && (s_r.st == eau_pkg::EAU_ST_IDLE);
  assign add_now   = !s_r.ind && (s_r.ofs != 15'h0000);
  assign xlat_done = !add_now && (!map_enable_i || xlat_ack_i);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      eau_pkg::EAU_ST_IDLE: begin
        if (req_valid_i) begin
          s_nxt.st     = eau_pkg::EAU_ST_XLAT;
          s_nxt.lvl    = 4'h0;
          s_nxt.ofs    = 15'h0000;
          s_nxt.bsel   = 1'b0;
          s_nxt.bitpos = 4'h0;
          case (req_kind_i)
            eau_pkg::EAU_KIND_BYTE: begin
              s_nxt.ia   = byte_ptr_i[15:1];
              s_nxt.bsel = byte_ptr_i[eau_pkg::BYTE_SEL_POS];
              s_nxt.ind  = 1'b0;
            end
            eau_pkg::EAU_KIND_BIT: begin
              // accumulators only read, never written
              s_nxt.ia  = same_acc_i ? 15'h0000 : src_acc_i[14:0];
              s_nxt.ind = !same_acc_i
                          && src_acc_i[eau_pkg::PTR_IND_POS];
              s_nxt.ofs = {3'h0, dst_acc_i[eau_pkg::BIT_OFS_LSB +:
                                           eau_pkg::BIT_OFS_W]};
              s_nxt.bitpos = dst_acc_i[eau_pkg::BIT_POS_W-1:0];
            end
            default: begin
              s_nxt.ia  = cif.ia;
              s_nxt.ind = cif.indirect;
            end
          endcase
        end
      end
      eau_pkg::EAU_ST_XLAT: begin
        if (add_now) begin
          // offset joins the resolved base, then translate again
          s_nxt.ia  = s_r.ia + s_r.ofs;
          s_nxt.ofs = 15'h0000;
        end else if (xlat_done) begin
          s_nxt.paddr = map_enable_i ? xlat_paddr_i
                                     : {5'h00, s_r.ia};
          if (!s_r.ind) begin
            s_nxt.st = eau_pkg::EAU_ST_DONE;
          end else if (indirect_prot_i && s_r.lvl >= LVL_LIMIT) begin
            s_nxt.st = eau_pkg::EAU_ST_FAULT;
          end else begin
            s_nxt.st = eau_pkg::EAU_ST_READ;
          end
        end
      end
      eau_pkg::EAU_ST_READ: begin
        if (mem_ack_i) begin
          s_nxt.ia  = mem_data_i[14:0];
          s_nxt.ind = mem_data_i[eau_pkg::PTR_IND_POS];
          s_nxt.st  = eau_pkg::EAU_ST_XLAT;
          if (s_r.lvl != 4'hf) begin
            s_nxt.lvl = s_r.lvl + 4'h1;
          end
        end
      end
      eau_pkg::EAU_ST_DONE:  s_nxt.st = eau_pkg::EAU_ST_IDLE;
      eau_pkg::EAU_ST_FAULT: s_nxt.st = eau_pkg::EAU_ST_IDLE;
      default:               s_nxt.st = eau_pkg::EAU_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '{st: eau_pkg::EAU_ST_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign xlat_req_o   = (s_r.st == eau_pkg::EAU_ST_XLAT) && !add_now
                        && map_enable_i;
  assign xlat_laddr_o = s_r.ia;
  assign mem_rd_o     = (s_r.st == eau_pkg::EAU_ST_READ);
  assign mem_paddr_o  = s_r.paddr;
  assign busy_o       = (s_r.st != eau_pkg::EAU_ST_IDLE);
  assign done_o       = (s_r.st == eau_pkg::EAU_ST_DONE);
  assign prot_fault_o = (s_r.st == eau_pkg::EAU_ST_FAULT);
  assign ea_o         = s_r.ia;
  assign ea_phys_o    = s_r.paddr;
  assign byte_sel_o   = s_r.bsel;
  assign bit_pos_o    = s_r.bitpos;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence seq_accept_word;
    accept && req_kind_i == eau_pkg::EAU_KIND_WORD;
  endsequence

  sequence seq_follow;
    mem_rd_o && mem_ack_i && mem_data_i[eau_pkg::PTR_IND_POS];
  endsequence

  sequence seq_end;
    mem_rd_o && mem_ack_i && !mem_data_i[eau_pkg::PTR_IND_POS]
    && s_r.ofs == 15'h0000;
  endsequence

  a_abs_short_disp: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    seq_accept_word and !extended_i && instr_i[9:8] == 2'h0
    |=> s_r.ia == {7'h00, $past(instr_i[7:0])})
    else $error("absolute short address not the displacement");

  a_acc2_rel_sum: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    cif.mode == eau_pkg::MODE_AC2
    |-> 15'(cif.ia - base_accumulator_two_i[14:0]) == cif.disp)
    else $error("acc2 relative sum wrong");

  a_pc_rel_sum: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    cif.mode == eau_pkg::MODE_PC && !extended_i
    |-> 15'(cif.ia - pc_i[14:0])
        == {{7{instr_i[7]}}, instr_i[7:0]})
    else $error("pc relative short sum wrong");

  a_xlat_before_read: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    $rose(mem_rd_o) |-> $past(s_r.st) == eau_pkg::EAU_ST_XLAT)
    else $error("pointer read without translation");

  a_chain_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    seq_follow |=> s_r.st == eau_pkg::EAU_ST_XLAT
                   && s_r.ia == $past(mem_data_i[14:0]) && s_r.ind)
    else $error("indirect pointer not followed");

  a_chain_end: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    seq_end ##1 (!map_enable_i) |=> done_o)
    else $error("direct pointer did not finish");

  a_level_limit: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    indirect_prot_i && $stable(indirect_prot_i) && mem_rd_o
    |-> s_r.lvl < LVL_LIMIT)
    else $error("protected chain passed level limit");

  a_fault_abort: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    prot_fault_o |-> !mem_rd_o ##1 !busy_o && !done_o)
    else $error("fault did not abort the access");

  a_byte_direct: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    accept && req_kind_i == eau_pkg::EAU_KIND_BYTE
    |=> s_r.ia == $past(byte_ptr_i[15:1]) && !s_r.ind
        && byte_sel_o == $past(byte_ptr_i[0])
        ##1 !mem_rd_o [*2])
    else $error("byte pointer not direct");

  a_bit_same_acc: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    accept && req_kind_i == eau_pkg::EAU_KIND_BIT && same_acc_i
    |=> s_r.ia == 15'h0000 && !s_r.ind
        && bit_pos_o == $past(dst_acc_i[3:0]))
    else $error("same accumulator base not zero");

endmodule : eau_top

// File: src/eau_pkg.sv
// shared constants and types for the effective address unit
package eau_pkg;

  localparam int LADDR_W   = 15;
  localparam int PADDR_W   = 20;
  localparam int WORD_W    = 16;
  localparam int LVL_W     = 4;
  localparam int LEVEL_MAX = 15;

  // index bits (mode select)
  localparam logic [1:0] MODE_ABS = 2'h0;
  localparam logic [1:0] MODE_PC  = 2'h1;
  localparam logic [1:0] MODE_AC2 = 2'h2;
  localparam logic [1:0] MODE_AC3 = 2'h3;

  // where an extended instruction keeps its index bits
  localparam logic [1:0] FLD_B12 = 2'h0;
  localparam logic [1:0] FLD_B34 = 2'h1;
  localparam logic [1:0] FLD_B67 = 2'h2;

  // field positions, vector index = 15 - printed bit number
  localparam int SH_IND_POS    = 10;
  localparam int SH_MODE_LSB   = 8;
  localparam int SH_DISP_W     = 8;
  localparam int B12_MODE_LSB  = 13;
  localparam int B34_MODE_LSB  = 11;
  localparam int PTR_IND_POS   = 15;
  localparam int BYTE_SEL_POS  = 0;
  localparam int BIT_OFS_LSB   = 4;
  localparam int BIT_OFS_W     = 12;
  localparam int BIT_POS_W     = 4;

  typedef enum logic [1:0] {
    EAU_KIND_WORD = 2'h0,
    EAU_KIND_BYTE = 2'h1,
    EAU_KIND_BIT  = 2'h2
  } eau_kind_t;

  // gray along idle -> translate -> read -> translate and done -> idle; translate -> done flips two bits
  typedef enum logic [2:0] {
    EAU_ST_IDLE  = 3'h0,
    EAU_ST_XLAT  = 3'h1,
    EAU_ST_READ  = 3'h3,
    EAU_ST_DONE  = 3'h2,
    EAU_ST_FAULT = 3'h6
  } eau_state_t;

endpackage : eau_pkg

// File: src/eau_calc_if.sv
// interface between the sequencer and the intermediate address adder
`timescale 1ns/100ps
interface eau_calc_if;
  logic [15:0] instr;
  logic [15:0] ext_word;
  logic        extended;
  logic [1:0]  fld;
  logic [15:0] pc;
  logic [15:0] acc2;
  logic [15:0] acc3;
  logic [1:0]  mode;
  logic [14:0] disp;
  logic [14:0] ia;
  logic        indirect;

  modport calc (input  instr, ext_word, extended, fld, pc, acc2, acc3,
                output mode, disp, ia, indirect);
  modport user (output instr, ext_word, extended, fld, pc, acc2, acc3,
                input  mode, disp, ia, indirect);
endinterface : eau_calc_if

// File: src/eau_calc.sv
// decode of address fields and intermediate address sum
`timescale 1ns/100ps
module eau_calc (
  eau_calc_if.calc cif
);

  logic [1:0]  ext_mode;
  logic [7:0]  sh_disp;
  logic [14:0] base;

  always_comb begin
    case (cif.fld)
      eau_pkg::FLD_B12:
        ext_mode = cif.instr[eau_pkg::B12_MODE_LSB +: 2];
      eau_pkg::FLD_B34:
        ext_mode = cif.instr[eau_pkg::B34_MODE_LSB +: 2];
      default:
        ext_mode = cif.instr[eau_pkg::SH_MODE_LSB +: 2];
    endcase
  end

  assign sh_disp = cif.instr[eau_pkg::SH_DISP_W-1:0];

  always_comb begin
    if (cif.extended) begin
      cif.mode     = ext_mode;
      cif.indirect = cif.ext_word[eau_pkg::PTR_IND_POS];
      cif.disp     = cif.ext_word[14:0];
    end else begin
      cif.mode     = cif.instr[eau_pkg::SH_MODE_LSB +: 2];
      cif.indirect = cif.instr[eau_pkg::SH_IND_POS];
      // zero extend for absolute, sign extend otherwise
      if (cif.mode == eau_pkg::MODE_ABS) begin
        cif.disp = {7'h00, sh_disp};
      end else begin
        cif.disp = {{7{sh_disp[7]}}, sh_disp};
      end
    end
  end

  // top bit of every base is dropped
  always_comb begin
    case (cif.mode)
      eau_pkg::MODE_PC:  base = cif.pc[14:0];
      eau_pkg::MODE_AC2: base = cif.acc2[14:0];
      eau_pkg::MODE_AC3: base = cif.acc3[14:0];
      default:           base = 15'h0000;
    endcase
  end

  // carry out of bit 14 discarded
  assign cif.ia = base + cif.disp;

endmodule : eau_calc

// File: verif/eau_far_model.sv
// translation unit and pointer memory model facing the address unit
`timescale 1ns/100ps
module eau_far_model #(
  parameter logic [4:0] MAP_PAGE = 5'h0b
) (
  input  wire logic        clock_i,
  input  wire logic [3:0]  wait_i,
  input  wire logic        xlat_req_i,
  input  wire logic [14:0] xlat_laddr_i,
  output logic             xlat_ack_o,
  output logic [19:0]      xlat_paddr_o,
  input  wire logic        mem_rd_i,
  input  wire logic [19:0] mem_paddr_i,
  output logic             mem_ack_o,
  output logic [15:0]      mem_data_o
);
  logic [15:0] mem [logic [19:0]];
  int          xc;
  int          mc;

  initial begin
    xlat_ack_o   = 1'b0;
    xlat_paddr_o = 20'h0;
    mem_ack_o    = 1'b0;
    mem_data_o   = 16'h0;
    xc           = 0;
    mc           = 0;
    forever begin
      @(posedge clock_i);
      #1;
      // released answers show no stale value
      if (xlat_ack_o) begin
        xlat_ack_o   = 1'b0;
        xlat_paddr_o = ~xlat_paddr_o;
      end else if (xlat_req_i && xc >= int'(wait_i)) begin
        xlat_ack_o   = 1'b1;
        xlat_paddr_o = {MAP_PAGE, xlat_laddr_i};
        xc           = 0;
      end else if (xlat_req_i) begin
        xc++;
      end
      if (mem_ack_o) begin
        mem_ack_o  = 1'b0;
        mem_data_o = ~mem_data_o;
      end else if (mem_rd_i && mc >= int'(wait_i)) begin
        mem_ack_o  = 1'b1;
        mem_data_o = mem.exists(mem_paddr_i) ? mem[mem_paddr_i] : 16'h0;
        mc         = 0;
      end else if (mem_rd_i) begin
        mc++;
      end
    end
  end
endmodule : eau_far_model

// File: verif/test_effective_address_unit.sv
// self-checking bench for the effective address unit
`timescale 1ns/100ps
module test_effective_address_unit;
  localparam logic [4:0] PG = 5'h0b;
  logic               clock_i, resetn_i, req_valid_i, extended_i, same_acc_i;
  logic               map_enable_i, indirect_prot_i, xlat_req_o, xlat_ack_i;
  logic               mem_rd_o, mem_ack_i, busy_o, done_o, prot_fault_o;
  logic               byte_sel_o;
  logic [1:0]         ext_field_i;
  logic [3:0]         bit_pos_o, wait_cyc;
  logic [14:0]        xlat_laddr_o, ea_o;
  logic [15:0]        instr_i, ext_word_i, pc_i, acc2, acc3, byte_ptr_i;
  logic [15:0]        src_acc_i, dst_acc_i, mem_data_i;
  logic [19:0]        xlat_paddr_i, mem_paddr_o, ea_phys_o;
  eau_pkg::eau_kind_t req_kind_i;
  int                 err_count, check_count, rd_count, lat;

  eau_top eau_top_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_kind_i(req_kind_i), .extended_i(extended_i),
    .ext_field_i(ext_field_i), .instr_i(instr_i), .ext_word_i(ext_word_i),
    .pc_i(pc_i), .base_accumulator_two_i(acc2),
    .base_accumulator_three_i(acc3), .byte_ptr_i(byte_ptr_i),
    .src_acc_i(src_acc_i), .dst_acc_i(dst_acc_i), .same_acc_i(same_acc_i),
    .map_enable_i(map_enable_i), .indirect_prot_i(indirect_prot_i),
    .xlat_req_o(xlat_req_o), .xlat_laddr_o(xlat_laddr_o),
    .xlat_ack_i(xlat_ack_i), .xlat_paddr_i(xlat_paddr_i),
    .mem_rd_o(mem_rd_o), .mem_paddr_o(mem_paddr_o), .mem_ack_i(mem_ack_i),
    .mem_data_i(mem_data_i), .busy_o(busy_o), .done_o(done_o),
    .prot_fault_o(prot_fault_o), .ea_o(ea_o), .ea_phys_o(ea_phys_o),
    .byte_sel_o(byte_sel_o), .bit_pos_o(bit_pos_o));

  eau_far_model eau_far_model_inst (
    .clock_i(clock_i), .wait_i(wait_cyc), .xlat_req_i(xlat_req_o),
    .xlat_laddr_i(xlat_laddr_o), .xlat_ack_o(xlat_ack_i),
    .xlat_paddr_o(xlat_paddr_i), .mem_rd_i(mem_rd_o),
    .mem_paddr_i(mem_paddr_o), .mem_ack_o(mem_ack_i),
    .mem_data_o(mem_data_i));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
    if (mem_rd_o === 1'b1 && mem_ack_i === 1'b1) rd_count++;

  task automatic chk(input logic [19:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [15:0] sh(logic ind, logic [1:0] m, logic [7:0] d);
    return {5'h0, ind, m, d};
  endfunction : sh

  // one request, then wait for done or fault
  task automatic issue(input eau_pkg::eau_kind_t k, input logic ext,
                       input logic [1:0] f, input logic [15:0] ins, ew);
    repeat (2) @(posedge clock_i);
    #1;
    req_kind_i  = k;
    extended_i  = ext;
    ext_field_i = f;
    instr_i     = ins;
    ext_word_i  = ew;
    req_valid_i = 1'b1;
    rd_count    = 0;
    @(posedge clock_i);
    #1;
    req_valid_i = 1'b0;
    lat = 1;
    while (done_o !== 1'b1 && prot_fault_o !== 1'b1 && lat < 500) begin
      @(posedge clock_i);
      #1;
      lat++;
    end
  endtask : issue

  task automatic t_modes;
    logic [7:0]  d [4] = '{8'hff, 8'h0a, 8'h80, 8'h01};
    logic [14:0] e [4] = '{15'h00ff, 15'h0006, 15'h7f85, 15'h0000};
    for (int i = 0; i < 4; i++) begin
      issue(eau_pkg::EAU_KIND_WORD, 1'b0, 2'h0, sh(1'b0, 2'(i), d[i]), 16'h0);
      chk(20'(ea_o), 20'(e[i]), "short ea");
      chk(20'(lat), 20'h2, "direct latency");
      chk(ea_phys_o, {5'h0, e[i]}, "unmapped phys");
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_ext;
    logic [15:0] ins;
    for (int f = 0; f < 3; f++) begin
      ins = (f == 0) ? 16'h2000 : (f == 1) ? 16'h0800 : 16'h0100;
      issue(eau_pkg::EAU_KIND_WORD, 1'b1, 2'(f), ins, 16'h7ffc);
      chk(20'(ea_o), 20'h07ff8, "ext pc ea");
    end
    issue(eau_pkg::EAU_KIND_WORD, 1'b1, 2'h2, 16'h0, 16'h7fff);
    chk(20'(ea_o), 20'h07fff, "ext abs ea");
    $display("test extended done");
  endtask : t_ext

  task automatic t_chain;
    map_enable_i = 1'b1;
    wait_cyc = 4'h2;
    eau_far_model_inst.mem[{PG, 15'h0010}] = 16'h8020;
    eau_far_model_inst.mem[{PG, 15'h0020}] = 16'h0345;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) issue(eau_pkg::EAU_KIND_WORD, 1'b0, 2'h0, sh(1'b1, 2'h0, 8'h10), 16'h0);
      else issue(eau_pkg::EAU_KIND_WORD, 1'b1, 2'h2, 16'h0, 16'h8010);
      chk(20'(ea_o), 20'h00345, "chain ea");
      chk(ea_phys_o, {PG, 15'h0345}, "mapped phys");
      chk(20'(rd_count), 20'h2, "chain reads");
    end
    map_enable_i = 1'b0;
    wait_cyc = 4'h0;
    $display("test chain done");
  endtask : t_chain

  task automatic t_prot;
    for (int i = 0; i < 20; i++)
      eau_far_model_inst.mem[20'h00100 + 20'(i)] =
        (i < 19) ? 16'h8101 + 16'(i) : 16'h0777;
    eau_far_model_inst.mem[20'h00040] = 16'h8040;
    indirect_prot_i = 1'b1;
    issue(eau_pkg::EAU_KIND_WORD, 1'b0, 2'h0, sh(1'b1, 2'h0, 8'h40), 16'h0);
    chk(20'(prot_fault_o), 20'h1, "loop faulted");
    chk(20'(done_o), 20'h0, "no done on fault");
    chk(20'(rd_count), 20'd15, "reads before fault");
    issue(eau_pkg::EAU_KIND_WORD, 1'b1, 2'h2, 16'h0, 16'h8105);
    chk(20'(done_o), 20'h1, "fifteen levels allowed");
    chk(20'(ea_o), 20'h00777, "fifteen level ea");
    indirect_prot_i = 1'b0;
    issue(eau_pkg::EAU_KIND_WORD, 1'b1, 2'h2, 16'h0, 16'h8100);
    chk(20'(ea_o), 20'h00777, "long chain ea");
    chk(20'(rd_count), 20'd20, "unprotected reads");
    $display("test protection done");
  endtask : t_prot

  task automatic t_byte;
    byte_ptr_i = 16'h0227;
    issue(eau_pkg::EAU_KIND_BYTE, 1'b0, 2'h0, 16'h0, 16'h0);
    chk(20'(ea_o), 20'h00113, "byte word");
    chk(20'(byte_sel_o), 20'h1, "byte select high");
    byte_ptr_i = 16'h8000;
    issue(eau_pkg::EAU_KIND_BYTE, 1'b0, 2'h0, 16'h0, 16'h0);
    chk(20'(ea_o), 20'h04000, "byte top bit");
    chk(20'(byte_sel_o), 20'h0, "byte select low");
    chk(20'(rd_count), 20'h0, "byte no read");
    $display("test byte done");
  endtask : t_byte

  task automatic t_bit;
    map_enable_i = 1'b1;
    wait_cyc = 4'h1;
    eau_far_model_inst.mem[{PG, 15'h0050}] = 16'h0041;
    src_acc_i = 16'h0041;
    dst_acc_i = 16'h0035;
    issue(eau_pkg::EAU_KIND_BIT, 1'b0, 2'h0, 16'h0, 16'h0);
    chk(20'(ea_o), 20'h00044, "bit ea");
    chk(20'(bit_pos_o), 20'h5, "bit position");
    chk(ea_phys_o, {PG, 15'h0044}, "bit phys");
    same_acc_i = 1'b1;
    src_acc_i = 16'h0035;
    issue(eau_pkg::EAU_KIND_BIT, 1'b0, 2'h0, 16'h0, 16'h0);
    chk(20'(ea_o), 20'h00003, "same acc ea");
    same_acc_i = 1'b0;
    src_acc_i = 16'h8050;
    dst_acc_i = 16'hfffc;
    issue(eau_pkg::EAU_KIND_BIT, 1'b0, 2'h0, 16'h0, 16'h0);
    chk(20'(ea_o), 20'h01040, "indirect base ea");
    chk(20'(bit_pos_o), 20'hc, "bit position twelve");
    chk(20'(rd_count), 20'h1, "base read");
    $display("test bit done");
  endtask : t_bit

  initial begin
    {resetn_i, req_valid_i, extended_i, same_acc_i} = 4'h0;
    {map_enable_i, indirect_prot_i, ext_field_i} = 4'h0;
    {instr_i, ext_word_i, byte_ptr_i, src_acc_i, dst_acc_i} = 80'h0;
    {pc_i, acc2, acc3} = {16'hfffc, 16'h0005, 16'hffff};
    req_kind_i = eau_pkg::EAU_KIND_WORD;
    wait_cyc = 4'h0;
    {err_count, check_count, rd_count, lat} = 128'h0;
    repeat (16) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    chk({busy_o, done_o, prot_fault_o, ea_o}, 20'h0, "reset outputs");
    t_modes();
    t_ext();
    t_chain();
    t_prot();
    t_byte();
    t_bit();
    print_verdict();
  end

  initial begin
    #200000;
    err_count++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : test_effective_address_unit
